// file: timer16_pkg.sv
// Functional notes
// - A tick source select of zero produces no ticks and the counter holds.
// - Counter value 0x0000 is bottom and 0xFFFF is maximum, both flagged internally.
// - One shared 8-bit holding register carries the upper byte of 16-bit accesses.
// - Writing a low byte loads holding byte and written byte together in one cycle.
// - Reading the counter low byte copies the counter upper byte into the holding register.
// - Compare A upper byte reads come straight from the register, holding register untouched.
// - Counter upper address reaches the holding register; counter changes on low write.
// - Each tick clears or increments the counter as the mode requires; it never decrements.
// - A counter write wins over a clear or count in the same cycle.
// - The counter stays readable and writable with or without a tick source.
// - Counter equal to compare A sets the compare A flag at the next tick.
// - Compare A enable and compare A flag both set raise the compare A request.
// - Compare A flag clears on interrupt service or on a software write of one.
// - Only software writes change the compare A value.
// - A counter write suppresses any compare match at the next tick, even stopped.
// - The wrap flag is set where the mode dictates and can raise a request.
// - Top of count is compare A in some modes and a fixed constant in others.
// - Normal mode counts up, wraps 0xFFFF to 0x0000, sets wrap flag then.
// - Mode 4 clears the counter on compare A match; mode 0 normal, rest reserved.
// - Select codes 1 to 5 divide by 1, 8, 64, 256, 1024; 6 and 7 reserved.
package timer16_pkg;

  // Register indices; the byte address is four times the index.
  localparam logic [7:0] IDX_CONTROL_A = 8'h80;
  localparam logic [7:0] IDX_CONTROL_B = 8'h81;
  localparam logic [7:0] IDX_COUNT_LOWER = 8'h84;
  localparam logic [7:0] IDX_COUNT_UPPER = 8'h85;
  localparam logic [7:0] IDX_COMPARE_LOWER = 8'h88;
  localparam logic [7:0] IDX_COMPARE_UPPER = 8'h89;
  localparam logic [7:0] IDX_FLAG = 8'h90;
  localparam logic [7:0] IDX_MASK = 8'h91;
  localparam logic [7:0] IDX_POWER = 8'h92;

  // Field positions.
  localparam int WGM_LOW_POS = 0;
  localparam int TICK_SELECT_POS = 0;
  localparam int WGM_HIGH_POS = 3;
  localparam int WRAP_BIT = 0;
  localparam int COMPARE_A_BIT = 1;
  localparam int POWER_GATE_BIT = 0;

  // Reset values.
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COMPARE_RESET = 16'h0000;
  localparam logic [7:0] HOLD_RESET = 8'h00;
  localparam logic [2:0] WGM_RESET = 3'h0;
  localparam logic [2:0] TICK_SELECT_RESET = 3'h0;
  localparam logic [1:0] FLAGS_RESET = 2'h0;
  localparam logic [1:0] MASK_RESET = 2'h0;
  localparam logic POWER_GATE_RESET = 1'b0;

  // Count limits.
  localparam logic [15:0] COUNT_BOTTOM = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;

  // Waveform modes.
  localparam logic [2:0] WGM_NORMAL = 3'h0;
  localparam logic [2:0] WGM_CLEAR_ON_MATCH = 3'h4;

  // Tick source select codes and prescale ratios.
  localparam logic [2:0] TICK_OFF = 3'h0;
  localparam logic [2:0] TICK_DIV1 = 3'h1;
  localparam logic [2:0] TICK_DIV8 = 3'h2;
  localparam logic [2:0] TICK_DIV64 = 3'h3;
  localparam logic [2:0] TICK_DIV256 = 3'h4;
  localparam logic [2:0] TICK_DIV1024 = 3'h5;
  localparam int PRESCALE_WIDTH = 10;
  localparam logic [9:0] RATIO_8 = 10'h007;
  localparam logic [9:0] RATIO_64 = 10'h03F;
  localparam logic [9:0] RATIO_256 = 10'h0FF;
  localparam logic [9:0] RATIO_1024 = 10'h3FF;

  typedef enum logic [3:0] {
    SEL_NONE = 4'b0000,
    SEL_CONTROL_A = 4'b0001,
    SEL_CONTROL_B = 4'b0010,
    SEL_COUNT_LOWER = 4'b0011,
    SEL_COUNT_UPPER = 4'b0100,
    SEL_COMPARE_LOWER = 4'b0101,
    SEL_COMPARE_UPPER = 4'b0110,
    SEL_FLAG = 4'b0111,
    SEL_MASK = 4'b1000,
    SEL_POWER = 4'b1001
  } reg_sel_type;

endpackage : timer16_pkg

// file: tick_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tick_if;
  logic [2:0] select;
  logic run;
  logic tick;
  modport source (input select, input run, output tick);
  modport user (output select, output run, input tick);
endinterface : tick_if
`default_nettype wire

// file: tick_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
module tick_prescaler (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Tick request and tick pulse
  tick_if.source tk
);

  typedef struct packed {
    logic [timer16_pkg::PRESCALE_WIDTH-1:0] div;
    logic tick;
  } pre_state_type;

  pre_state_type st_reg;
  pre_state_type st_next;

  always_comb begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (tk.run) begin
      st_next.div = st_reg.div + 10'h001;
      case (tk.select)
        timer16_pkg::TICK_DIV1: st_next.tick = 1'b1;
        timer16_pkg::TICK_DIV8: st_next.tick = (st_reg.div & timer16_pkg::RATIO_8) == timer16_pkg::RATIO_8;
        timer16_pkg::TICK_DIV64: st_next.tick = (st_reg.div & timer16_pkg::RATIO_64) == timer16_pkg::RATIO_64;
        timer16_pkg::TICK_DIV256: st_next.tick = (st_reg.div & timer16_pkg::RATIO_256) == timer16_pkg::RATIO_256;
        timer16_pkg::TICK_DIV1024: st_next.tick = st_reg.div == timer16_pkg::RATIO_1024;
        default: st_next.tick = 1'b0;
      endcase
    end else begin
      // The divider restarts so that the first period after a start is whole.
      st_next.div = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tk.tick = st_reg.tick;

endmodule : tick_prescaler
`default_nettype wire

// file: timer16.sv
// Chosen here: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module timer16 #(
  parameter int ADDR_WIDTH = 12
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt requests and service acknowledges
  output logic compare_a_irq,
  output logic wrap_irq,
  input wire logic compare_a_ack,
  input wire logic wrap_ack
);

  typedef struct packed {
    logic [15:0] count_value;
    logic [15:0] compare_a_value;
    logic [7:0] hold;
    logic [2:0] waveform_mode_field;
    logic [2:0] tick_source_select;
    logic [1:0] flags;
    logic [1:0] mask;
    logic timer_power_gate_bit;
    logic match_block;
    logic answered;
    logic [7:0] rdata;
  } state_type;

  state_type st_reg;
  state_type st_next;
  timer16_pkg::reg_sel_type sel;
  logic [7:0] wdata;
  logic access;
  logic capture;
  logic commit;
  logic tick;
  logic at_bottom;
  logic at_max;
  logic match;
  logic ctc_mode;
  logic compare_event;
  logic ctc_clear;
  logic wrap_event;
  logic [7:0] read_value;

  tick_if tk ();

  tick_prescaler u_prescaler (
    .pclk(pclk),
    .presetn(presetn),
    .tk(tk)
  );

  function automatic logic [ADDR_WIDTH-1:0] addr_of(input logic [7:0] idx);
    return ADDR_WIDTH'({idx, 2'b00});
  endfunction : addr_of

  // Address decode.
  always_comb begin
    if (paddr == addr_of(timer16_pkg::IDX_CONTROL_A)) begin
      sel = timer16_pkg::SEL_CONTROL_A;
    end else if (paddr == addr_of(timer16_pkg::IDX_CONTROL_B)) begin
      sel = timer16_pkg::SEL_CONTROL_B;
    end else if (paddr == addr_of(timer16_pkg::IDX_COUNT_LOWER)) begin
      sel = timer16_pkg::SEL_COUNT_LOWER;
    end else if (paddr == addr_of(timer16_pkg::IDX_COUNT_UPPER)) begin
      sel = timer16_pkg::SEL_COUNT_UPPER;
    end else if (paddr == addr_of(timer16_pkg::IDX_COMPARE_LOWER)) begin
      sel = timer16_pkg::SEL_COMPARE_LOWER;
    end else if (paddr == addr_of(timer16_pkg::IDX_COMPARE_UPPER)) begin
      sel = timer16_pkg::SEL_COMPARE_UPPER;
    end else if (paddr == addr_of(timer16_pkg::IDX_FLAG)) begin
      sel = timer16_pkg::SEL_FLAG;
    end else if (paddr == addr_of(timer16_pkg::IDX_MASK)) begin
      sel = timer16_pkg::SEL_MASK;
    end else if (paddr == addr_of(timer16_pkg::IDX_POWER)) begin
      sel = timer16_pkg::SEL_POWER;
    end else begin
      sel = timer16_pkg::SEL_NONE;
    end
  end

  // Read multiplexer; reserved bits read as zero.
  always_comb begin
    read_value = 8'h00;
    case (sel)
      timer16_pkg::SEL_CONTROL_A: begin
        read_value[timer16_pkg::WGM_LOW_POS +: 2] = st_reg.waveform_mode_field[1:0];
      end
      timer16_pkg::SEL_CONTROL_B: begin
        read_value[timer16_pkg::WGM_HIGH_POS] = st_reg.waveform_mode_field[2];
        read_value[timer16_pkg::TICK_SELECT_POS +: 3] = st_reg.tick_source_select;
      end
      timer16_pkg::SEL_COUNT_LOWER: read_value = st_reg.count_value[7:0];
      timer16_pkg::SEL_COUNT_UPPER: read_value = st_reg.hold;
      timer16_pkg::SEL_COMPARE_LOWER: read_value = st_reg.compare_a_value[7:0];
      timer16_pkg::SEL_COMPARE_UPPER: read_value = st_reg.compare_a_value[15:8];
      timer16_pkg::SEL_FLAG: read_value[1:0] = st_reg.flags;
      timer16_pkg::SEL_MASK: read_value[1:0] = st_reg.mask;
      timer16_pkg::SEL_POWER: read_value[timer16_pkg::POWER_GATE_BIT] = st_reg.timer_power_gate_bit;
      default: read_value = 8'h00;
    endcase
  end

  // The access phase takes two cycles: read data and read side effects are
  // caught in the first, and writes take effect at the edge that ends the second.
  assign access = psel & penable;
  assign capture = access & ~st_reg.answered;
  assign commit = access & st_reg.answered;
  assign wdata = pwdata[7:0];

  // Gated or unselected, the prescaler gets no run request.
  assign tk.select = st_reg.tick_source_select;
  assign tk.run = ~st_reg.timer_power_gate_bit & (st_reg.tick_source_select != timer16_pkg::TICK_OFF);
  assign tick = tk.tick & tk.run;

  assign at_bottom = st_reg.count_value == timer16_pkg::COUNT_BOTTOM;
  assign at_max = st_reg.count_value == timer16_pkg::COUNT_MAX;
  assign match = st_reg.count_value == st_reg.compare_a_value;
  assign ctc_mode = st_reg.waveform_mode_field == timer16_pkg::WGM_CLEAR_ON_MATCH;
  assign compare_event = tick & match & ~st_reg.match_block;
  assign ctc_clear = ctc_mode & compare_event;
  assign wrap_event = tick & at_max;

  always_comb begin
    st_next = st_reg;
    st_next.answered = capture;

    // Counting; the counter increments on each tick, or clears to bottom on a compare A match in mode 4.
    if (tick) begin
      if (ctc_clear) begin
        st_next.count_value = timer16_pkg::COUNT_BOTTOM;
      end else begin
        st_next.count_value = st_reg.count_value + 16'h0001;
      end
      st_next.match_block = 1'b0;
    end

    if (capture & ~pwrite & (sel == timer16_pkg::SEL_COUNT_LOWER)) begin
      st_next.hold = st_reg.count_value[15:8];
    end
    if (capture & ~pwrite) begin
      st_next.rdata = read_value;
    end

    // Flags: hardware clears first, so a set in the same cycle wins.
    if (compare_a_ack) begin
      st_next.flags[timer16_pkg::COMPARE_A_BIT] = 1'b0;
    end
    if (wrap_ack) begin
      st_next.flags[timer16_pkg::WRAP_BIT] = 1'b0;
    end
    if (commit & pwrite & (sel == timer16_pkg::SEL_FLAG)) begin
      st_next.flags = st_next.flags & ~wdata[1:0];
    end
    if (compare_event) begin
      st_next.flags[timer16_pkg::COMPARE_A_BIT] = 1'b1;
    end
    if (wrap_event) begin
      st_next.flags[timer16_pkg::WRAP_BIT] = 1'b1;
    end

    if (commit & pwrite) begin
      case (sel)
        timer16_pkg::SEL_CONTROL_A: begin
          st_next.waveform_mode_field[1:0] = wdata[timer16_pkg::WGM_LOW_POS +: 2];
        end
        timer16_pkg::SEL_CONTROL_B: begin
          st_next.waveform_mode_field[2] = wdata[timer16_pkg::WGM_HIGH_POS];
          st_next.tick_source_select = wdata[timer16_pkg::TICK_SELECT_POS +: 3];
        end
        timer16_pkg::SEL_COUNT_LOWER: begin
          st_next.count_value = {st_reg.hold, wdata};
          st_next.match_block = 1'b1;
        end
        timer16_pkg::SEL_COUNT_UPPER: st_next.hold = wdata;
        timer16_pkg::SEL_COMPARE_LOWER: begin
          st_next.compare_a_value = {st_reg.hold, wdata};
        end
        timer16_pkg::SEL_COMPARE_UPPER: st_next.hold = wdata;
        timer16_pkg::SEL_MASK: st_next.mask = wdata[1:0];
        timer16_pkg::SEL_POWER: begin
          st_next.timer_power_gate_bit = wdata[timer16_pkg::POWER_GATE_BIT];
        end
        default: st_next.hold = st_reg.hold;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg.count_value <= timer16_pkg::COUNT_RESET;
      st_reg.compare_a_value <= timer16_pkg::COMPARE_RESET;
      st_reg.hold <= timer16_pkg::HOLD_RESET;
      st_reg.waveform_mode_field <= timer16_pkg::WGM_RESET;
      st_reg.tick_source_select <= timer16_pkg::TICK_SELECT_RESET;
      st_reg.flags <= timer16_pkg::FLAGS_RESET;
      st_reg.mask <= timer16_pkg::MASK_RESET;
      st_reg.timer_power_gate_bit <= timer16_pkg::POWER_GATE_RESET;
      st_reg.match_block <= 1'b0;
      st_reg.answered <= 1'b0;
      st_reg.rdata <= 8'h00;
    end else begin
      st_reg <= st_next;
    end
  end

  assign prdata = {24'h000000, st_reg.rdata};
  assign pready = commit;
  assign pslverr = commit & (sel == timer16_pkg::SEL_NONE);
  assign compare_a_irq = st_reg.flags[timer16_pkg::COMPARE_A_BIT] & st_reg.mask[timer16_pkg::COMPARE_A_BIT];
  assign wrap_irq = st_reg.flags[timer16_pkg::WRAP_BIT] & st_reg.mask[timer16_pkg::WRAP_BIT];

endmodule : timer16
`default_nettype wire

// file: timer16_sva.sv
`timescale 1ns/1ps
`default_nettype none
module timer16_sva #(
  parameter int ADDR_WIDTH = 12
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Interrupts
  input wire logic compare_a_irq,
  input wire logic wrap_irq,
  input wire logic compare_a_ack,
  input wire logic wrap_ack
);
  localparam logic [ADDR_WIDTH-1:0] A_CL = ADDR_WIDTH'({timer16_pkg::IDX_COMPARE_LOWER, 2'h0});
  localparam logic [ADDR_WIDTH-1:0] A_CH = ADDR_WIDTH'({timer16_pkg::IDX_COMPARE_UPPER, 2'h0});
  localparam logic [ADDR_WIDTH-1:0] A_NH = ADDR_WIDTH'({timer16_pkg::IDX_COUNT_UPPER, 2'h0});
  logic done;
  logic [7:0] hold_reg;
  logic [15:0] cmp_reg;
  assign done = psel && penable && pready;
  // Mirrors the compare value from completed writes so reads can be judged.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_reg <= 8'h00;
      cmp_reg <= 16'h0000;
    end else if (done && pwrite) begin
      if (paddr == A_CH || paddr == A_NH) begin
        hold_reg <= pwdata[7:0];
      end
      if (paddr == A_CL) begin
        cmp_reg <= {hold_reg, pwdata[7:0]};
      end
    end
  end
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s; psel && !penable; endsequence
  sequence access_s; psel && penable; endsequence
  sequence read_s(a); done && !pwrite && paddr == a; endsequence
  wait_state_a: assert property (setup_s ##1 access_s |-> !pready ##1 (psel && penable && pready))
    else $error("ready not in second access cycle");
  ready_phase_a: assert property (pready |-> psel && penable && $past(penable))
    else $error("ready outside access phase");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  bad_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h00000000)
    else $error("unmapped read not zero");
  narrow_data_a: assert property (done && !pwrite |-> prdata[31:8] == 24'h000000)
    else $error("read data above byte not zero");
  cmp_upper_a: assert property (read_s(A_CH) |-> prdata[7:0] == cmp_reg[15:8])
    else $error("compare upper read wrong");
  cmp_lower_a: assert property (read_s(A_CL) |-> prdata[7:0] == cmp_reg[7:0])
    else $error("compare lower read wrong");
  cmp_fall_a: assert property ($fell(compare_a_irq) |-> $past(compare_a_ack) || $past(done))
    else $error("compare request fell without cause");
  wrap_fall_a: assert property ($fell(wrap_irq) |-> $past(wrap_ack) || $past(done))
    else $error("wrap request fell without cause");
  reset_quiet_a: assert property ($rose(presetn) |-> !compare_a_irq && !wrap_irq)
    else $error("request active after reset");
endmodule : timer16_sva
bind timer16 timer16_sva #(.ADDR_WIDTH(ADDR_WIDTH)) i_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .compare_a_irq(compare_a_irq), .wrap_irq(wrap_irq), .compare_a_ack(compare_a_ack),
  .wrap_ack(wrap_ack));
`default_nettype wire

// file: cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_model (
  // Clock
  input wire logic pclk,
  // APB master
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Interrupt service
  output logic compare_a_ack,
  output logic wrap_ack
);
  logic last_err;
  initial begin
    {psel, penable, pwrite, compare_a_ack, wrap_ack, last_err} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h00000000;
  end
  task automatic xfer(input logic w, input logic [7:0] i, input logic [7:0] d,
                      output logic [31:0] q);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'h0, i, 2'h0};
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(negedge pclk); while (pready !== 1'b1);
    q = prdata;
    last_err = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    // Released data lines do not keep their last value.
    pwdata <= ~pwdata;
  endtask : xfer
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    logic [31:0] q;
    xfer(1'b1, i, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] i, output logic [31:0] q);
    xfer(1'b0, i, 8'h00, q);
  endtask : rd
  task automatic wr16(input logic [7:0] lo, input logic [15:0] v);
    wr(lo + 8'h01, v[15:8]);
    wr(lo, v[7:0]);
  endtask : wr16
  task automatic rd16(input logic [7:0] lo, output logic [15:0] v);
    logic [31:0] a;
    logic [31:0] b;
    rd(lo, a);
    rd(lo + 8'h01, b);
    v = {b[7:0], a[7:0]};
  endtask : rd16
  task automatic ack(input logic c);
    @(posedge pclk);
    compare_a_ack <= c;
    wrap_ack <= !c;
    @(posedge pclk);
    compare_a_ack <= 1'b0;
    wrap_ack <= 1'b0;
  endtask : ack
endmodule : cpu_model
`default_nettype wire

// file: timer16_test.sv
`timescale 1ns/1ps
`default_nettype none
module timer16_test;
  localparam logic [7:0] CB = timer16_pkg::IDX_CONTROL_B;
  localparam logic [7:0] CL = timer16_pkg::IDX_COUNT_LOWER;
  localparam logic [7:0] KL = timer16_pkg::IDX_COMPARE_LOWER;
  localparam logic [7:0] FL = timer16_pkg::IDX_FLAG;
  localparam logic [7:0] MK = timer16_pkg::IDX_MASK;
  localparam logic [7:0] PW = timer16_pkg::IDX_POWER;
  localparam logic [7:0] REGS [9] = '{timer16_pkg::IDX_CONTROL_A, CB, CL,
    timer16_pkg::IDX_COUNT_UPPER, KL, timer16_pkg::IDX_COMPARE_UPPER, FL, MK, PW};
  localparam int DIV [8] = '{0, 1, 8, 64, 256, 1024, 0, 0};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic compare_a_irq, wrap_irq, compare_a_ack, wrap_ack;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] v;
  int err_count, samples_checked, e;
  timer16 #(.ADDR_WIDTH(12)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .compare_a_irq(compare_a_irq), .wrap_irq(wrap_irq), .compare_a_ack(compare_a_ack),
    .wrap_ack(wrap_ack));
  cpu_model i_cpu (
    .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .compare_a_ack(compare_a_ack), .wrap_ack(wrap_ack));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish
  task automatic wait_irq(input logic c);
    @(negedge pclk);
    for (int n = 0; n < 200 && (c ? compare_a_irq : wrap_irq) !== 1'b1; n++) @(negedge pclk);
  endtask : wait_irq
  task automatic t_reset();
    foreach (REGS[k]) begin
      i_cpu.rd(REGS[k], q);
      chk(q, 32'h00000000);
    end
    i_cpu.wr(timer16_pkg::IDX_CONTROL_A, 8'hFF);
    i_cpu.rd(timer16_pkg::IDX_CONTROL_A, q);
    chk(q, 32'h00000003);
    i_cpu.wr(timer16_pkg::IDX_CONTROL_A, 8'h00);
    i_cpu.rd(8'hFF, q);
    chk({q[30:0], i_cpu.last_err}, 32'h00000001);
    $display("reset test done");
  endtask : t_reset
  task automatic t_bytes();
    i_cpu.wr16(CL, 16'h1234);
    i_cpu.rd16(CL, v);
    chk(32'(v), 32'h00001234);
    i_cpu.wr(CL + 8'h01, 8'h55);
    i_cpu.rd16(CL, v);
    chk(32'(v), 32'h00001234);
    i_cpu.wr16(KL, 16'hABCD);
    i_cpu.rd(KL + 8'h01, q);
    chk(q, 32'h000000AB);
    i_cpu.rd(CL + 8'h01, q);
    chk(q, 32'h000000AB);
    $display("byte access test done");
  endtask : t_bytes
  task automatic t_stop();
    i_cpu.wr16(CL, 16'h0100);
    repeat (50) @(posedge pclk);
    i_cpu.rd16(CL, v);
    chk(32'(v), 32'h00000100);
    i_cpu.wr(PW, 8'h01);
    i_cpu.wr(CB, 8'h01);
    repeat (50) @(posedge pclk);
    i_cpu.rd16(CL, v);
    chk(32'(v), 32'h00000100);
    i_cpu.wr(CB, 8'h00);
    i_cpu.wr(PW, 8'h00);
    $display("stop test done");
  endtask : t_stop
  task automatic t_wrap();
    i_cpu.wr16(CL, 16'hFFF0);
    i_cpu.wr(MK, 8'h01);
    i_cpu.wr(CB, 8'h01);
    wait_irq(1'b0);
    chk(32'(wrap_irq), 32'h00000001);
    i_cpu.wr(CB, 8'h00);
    i_cpu.rd16(CL, v);
    chk(32'(v < 16'h0040), 32'h00000001);
    i_cpu.ack(1'b0);
    @(negedge pclk);
    chk(32'(wrap_irq), 32'h00000000);
    $display("wrap test done");
  endtask : t_wrap
  task automatic t_ctc();
    i_cpu.wr16(KL, 16'h0005);
    i_cpu.wr16(CL, 16'h0000);
    i_cpu.wr(FL, 8'h03);
    i_cpu.wr(MK, 8'h02);
    i_cpu.wr(CB, 8'h09);
    wait_irq(1'b1);
    chk(32'(compare_a_irq), 32'h00000001);
    i_cpu.wr(CB, 8'h08);
    i_cpu.rd16(CL, v);
    chk(32'(v <= 16'h0005), 32'h00000001);
    i_cpu.ack(1'b1);
    @(negedge pclk);
    chk(32'(compare_a_irq), 32'h00000000);
    i_cpu.wr(CB, 8'h09);
    repeat (20) @(posedge pclk);
    i_cpu.wr(CB, 8'h08);
    @(negedge pclk);
    chk(32'(compare_a_irq), 32'h00000001);
    i_cpu.wr(FL, 8'h02);
    i_cpu.rd(FL, q);
    chk(q, 32'h00000000);
    $display("clear on match test done");
  endtask : t_ctc
  task automatic t_block();
    i_cpu.wr(CB, 8'h00);
    i_cpu.wr16(KL, 16'h0040);
    i_cpu.wr16(CL, 16'h0040);
    i_cpu.wr(CB, 8'h01);
    repeat (30) @(posedge pclk);
    i_cpu.rd16(CL, v);
    chk(32'(v > 16'h0040), 32'h00000001);
    // The counter ticks every cycle here, so this write meets a count.
    i_cpu.wr16(CL, 16'h2000);
    i_cpu.wr(CB, 8'h00);
    @(negedge pclk);
    chk(32'(compare_a_irq), 32'h00000000);
    i_cpu.rd16(CL, v);
    chk(32'(v >= 16'h2000 && v < 16'h2010), 32'h00000001);
    $display("match block test done");
  endtask : t_block
  task automatic t_rate();
    for (int c = 1; c < 8; c++) begin
      i_cpu.wr16(CL, 16'h0000);
      i_cpu.wr(CB, 8'(c));
      repeat (2048) @(posedge pclk);
      i_cpu.wr(CB, 8'h00);
      i_cpu.rd16(CL, v);
      e = (DIV[c] == 0) ? 0 : 2048 / DIV[c];
      chk(32'(int'(v) >= (e > 0 ? e - 1 : 0) && int'(v) <= (e > 0 ? e + 4 : 0)), 32'h1);
    end
    $display("tick rate test done");
  endtask : t_rate
  initial begin
    presetn = 1'b0;
    err_count = 0;
    samples_checked = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_bytes();
    t_stop();
    t_wrap();
    t_ctc();
    t_block();
    t_rate();
    tally_and_finish();
  end
  // The whole run needs about 15000 cycles; allow a wide margin.
  initial begin
    #(60000 * 25);
    err_count++;
    tally_and_finish();
  end
endmodule : timer16_test
`default_nettype wire
